// >>> rtl/i2csa_slave.sv
// i2c slave front end: address match, acknowledge, receive buffer and flags
`timescale 1ns/100ps
`include "i2csa_params.svh"

module i2csa_slave (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    // bus pins, open drain
    input  wire logic                    scl_in,
    output logic                         scl_out,
    output logic                         scl_oe,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe,
    // firmware control
    input  wire i2csa_pkg::i2csa_ctrl_s  ctrl,
    input  wire logic                    own_addr_wr,
    input  wire logic [7:0]              own_addr_wdata,
    input  wire logic                    rx_buffer_rd,
    input  wire logic                    irq_flag_clr,
    input  wire logic                    overflow_clr,
    // firmware status
    output logic [7:0]                   rx_buffer,
    output logic [7:0]                   own_address_reg,
    output i2csa_pkg::i2csa_status_s     status,
    output logic                         irq
);

    import i2csa_pkg::*;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [1:0]   pins_sync;
    logic         scl_s;
    logic         sda_s;

    i2csa_sync #(
        .WIDTH (2)
    ) u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    i2csa_state_s s;
    i2csa_state_s next_s;

    logic         scl_rise;
    logic         scl_fall;
    logic         start_cond;
    logic         stop_cond;
    logic         match7;
    logic         match_full;
    logic         ten_hdr;
    logic         addr_match;
    logic         take_byte;

    // ------------------------------------------------------------------------
    // edge and condition detection
    // ------------------------------------------------------------------------
    assign scl_rise   = scl_s & ~s.scl_d;
    assign scl_fall   = ~scl_s & s.scl_d;
    assign start_cond = scl_s & s.scl_d & s.sda_d & ~sda_s;
    assign stop_cond  = scl_s & s.scl_d & ~s.sda_d & sda_s;

    assign match7     = (s.rx_shift_reg[`I2CSA_ADDR_MSB:`I2CSA_ADDR_LSB] ==
                         s.own_address_reg[`I2CSA_ADDR_MSB:`I2CSA_ADDR_LSB]);
    assign match_full = (s.rx_shift_reg == s.own_address_reg);
    assign ten_hdr    = (s.rx_shift_reg[`I2CSA_TEN_PREFIX_MSB:`I2CSA_TEN_PREFIX_LSB] ==
                         `I2CSA_TEN_PREFIX);

    always_comb begin
        if (ctrl.ten_bit_mode && s.second_addr) begin
            addr_match = match_full;
        end else if (ctrl.ten_bit_mode && !s.ten_done) begin
            addr_match = ten_hdr & match7;
        end else if (ctrl.ten_bit_mode) begin
            // repeated start matches high byte only
            addr_match = ten_hdr & match7;
        end else begin
            addr_match = match7;
        end
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_s       = s;
        take_byte    = 1'b0;
        next_s.scl_d = scl_s;
        next_s.sda_d = sda_s;

        // firmware side effects; hardware sets below win over these clears
        // buffer read clears full
        if (rx_buffer_rd) begin
            next_s.bf = 1'b0;
        end
        if (irq_flag_clr) begin
            next_s.irq_flag = 1'b0;
        end
        if (overflow_clr) begin
            next_s.ov = 1'b0;
        end
        if (own_addr_wr) begin
            next_s.own_address_reg = own_addr_wdata;
            if (s.ua) begin
                // a write before the ninth fall must also cancel the hold, or it would stick
                next_s.ua           = 1'b0;
                next_s.scl_hold     = 1'b0;
                next_s.hold_pending = 1'b0;
            end
        end

        if (!ctrl.enable) begin
            next_s.state        = ST_IDLE;
            next_s.bit_cnt      = `I2CSA_CNT_ZERO;
            next_s.ack_drive    = 1'b0;
            next_s.scl_hold     = 1'b0;
            next_s.hold_pending = 1'b0;
            next_s.second_addr  = 1'b0;
            next_s.ten_done     = 1'b0;
            next_s.start_seen   = 1'b0;
            next_s.stop_seen    = 1'b0;
        end else if (start_cond) begin
            // start (or repeated start) opens an address byte
            next_s.state        = ST_ADDR;
            next_s.bit_cnt      = `I2CSA_CNT_ZERO;
            next_s.ack_drive    = 1'b0;
            next_s.byte_ok      = 1'b0;
            next_s.hold_pending = 1'b0;
            next_s.second_addr  = 1'b0;
            next_s.start_seen   = 1'b1;
            next_s.stop_seen    = 1'b0;
        end else if (stop_cond) begin
            next_s.state        = ST_IDLE;
            next_s.bit_cnt      = `I2CSA_CNT_ZERO;
            next_s.ack_drive    = 1'b0;
            next_s.hold_pending = 1'b0;
            next_s.second_addr  = 1'b0;
            next_s.ten_done     = 1'b0;
            next_s.start_seen   = 1'b0;
            next_s.stop_seen    = 1'b1;
        end else begin
            case (s.state)
                ST_ADDR, ST_DATA: begin
                    // bits taken on the bus clock rise
                    if (scl_rise && s.bit_cnt < `I2CSA_BYTE_BITS) begin
                        next_s.rx_shift_reg = {s.rx_shift_reg[6:0], sda_s};
                        next_s.bit_cnt      = s.bit_cnt + `I2CSA_CNT_ONE;
                    end else if (scl_rise && s.bit_cnt == `I2CSA_BYTE_BITS) begin
                        next_s.bit_cnt = `I2CSA_ACK_BIT;
                    end else if (scl_fall && s.bit_cnt == `I2CSA_BYTE_BITS) begin
                        if (s.state == ST_DATA) begin
                            take_byte        = 1'b1;
                            next_s.after_ack = ST_DATA;
                        end else if (addr_match) begin
                            take_byte = 1'b1;
                            if (ctrl.ten_bit_mode && s.second_addr) begin
                                next_s.ua           = 1'b1;
                                next_s.hold_pending = 1'b1;
                                next_s.second_addr  = 1'b0;
                                next_s.ten_done     = 1'b1;
                                next_s.after_ack    = ST_DATA;
                            end else if (ctrl.ten_bit_mode && !s.ten_done) begin
                                next_s.ua           = 1'b1;
                                next_s.hold_pending = 1'b1;
                                next_s.rw           = s.rx_shift_reg[`I2CSA_DIR_BIT];
                                // a read header cannot lead to a second byte
                                if (s.rx_shift_reg[`I2CSA_DIR_BIT]) begin
                                    next_s.after_ack = ST_SKIP;
                                end else begin
                                    next_s.second_addr = 1'b1;
                                    next_s.after_ack   = ST_ADDR;
                                end
                            end else begin
                                // direction bit of the matched address
                                next_s.rw = s.rx_shift_reg[`I2CSA_DIR_BIT];
                                // reads go to the transmitter, not handled here
                                next_s.after_ack = s.rx_shift_reg[`I2CSA_DIR_BIT] ? ST_SKIP : ST_DATA;
                            end
                        end else begin
                            next_s.state       = ST_SKIP;
                            next_s.bit_cnt     = `I2CSA_CNT_ZERO;
                            next_s.second_addr = 1'b0;
                        end
                    end else if (scl_fall && s.bit_cnt == `I2CSA_ACK_BIT) begin
                        next_s.ack_drive = 1'b0;
                        next_s.bit_cnt   = `I2CSA_CNT_ZERO;
                        next_s.state     = s.after_ack;
                        // irq flag on the ninth fall
                        if (s.byte_ok) begin
                            next_s.irq_flag = 1'b1;
                        end
                        next_s.byte_ok = 1'b0;
                        // stretch the clock until the address is updated
                        if (s.hold_pending) begin
                            next_s.scl_hold     = 1'b1;
                            next_s.hold_pending = 1'b0;
                        end
                    end
                end
                default: begin
                    next_s.bit_cnt   = `I2CSA_CNT_ZERO;
                    next_s.ack_drive = 1'b0;
                end
            endcase
        end

        // buffer and acknowledge decision, shared by address and data bytes
        if (take_byte) begin
            next_s.byte_ok = 1'b1;
            if (s.bf) begin
                // full buffer is kept, overflow raised
                next_s.ov = 1'b1;
            end else begin
                // load buffer and set full at eighth fall
                next_s.rx_buffer = s.rx_shift_reg;
                next_s.bf        = 1'b1;
                // overflow alone still updates the buffer
                // acknowledge only with both flags clear
                next_s.ack_drive = ~s.ov;
            end
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s                 <= '0;
            s.state           <= ST_IDLE;
            s.after_ack       <= ST_IDLE;
            s.rx_shift_reg    <= `I2CSA_SHIFT_RESET;
            s.rx_buffer       <= `I2CSA_BUFFER_RESET;
            s.own_address_reg <= `I2CSA_OWN_ADDR_RESET;
            s.scl_d           <= 1'b1;
            s.sda_d           <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // open drain: the driven level is always low, the enable decides
    assign scl_out         = 1'b0;
    assign scl_oe          = s.scl_hold;
    assign sda_out         = 1'b0;
    assign sda_oe          = s.ack_drive;
    assign rx_buffer       = s.rx_buffer;
    assign own_address_reg = s.own_address_reg;

    assign status.buffer_full_flag      = s.bf;
    assign status.receive_overflow_flag = s.ov;
    assign status.serial_port_irq_flag  = s.irq_flag;
    assign status.address_update_flag   = s.ua;
    assign status.read_write            = s.rw;
    assign status.start_seen            = s.start_seen;
    assign status.stop_seen             = s.stop_seen;

    assign irq = s.irq_flag & ctrl.irq_enable;

endmodule

// >>> rtl/i2csa_params.svh
// constants for the i2c slave address receive block
`ifndef I2CSA_PARAMS_SVH
`define I2CSA_PARAMS_SVH

// ----------------------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------------------
`define I2CSA_BYTE_BITS       4'h8
`define I2CSA_ACK_BIT         4'h9
`define I2CSA_CNT_ZERO        4'h0
`define I2CSA_CNT_ONE         4'h1

// ----------------------------------------------------------------------------
// address fields
// ----------------------------------------------------------------------------
`define I2CSA_TEN_PREFIX      5'h1e
`define I2CSA_TEN_PREFIX_MSB  7
`define I2CSA_TEN_PREFIX_LSB  3
`define I2CSA_ADDR_MSB        7
`define I2CSA_ADDR_LSB        1
`define I2CSA_DIR_BIT         0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define I2CSA_OWN_ADDR_RESET  8'h00
`define I2CSA_BUFFER_RESET    8'h00
`define I2CSA_SHIFT_RESET     8'h00

`endif

// >>> rtl/i2csa_pkg.sv
// types shared by the i2c slave address receive block
package i2csa_pkg;

    // ------------------------------------------------------------------------
    // protocol state
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_SKIP
    } i2csa_state_e;

    // ------------------------------------------------------------------------
    // firmware control and status groups
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic ten_bit_mode;
        logic irq_enable;
    } i2csa_ctrl_s;

    typedef struct packed {
        logic buffer_full_flag;
        logic receive_overflow_flag;
        logic serial_port_irq_flag;
        logic address_update_flag;
        logic read_write;
        logic start_seen;
        logic stop_seen;
    } i2csa_status_s;

    // ------------------------------------------------------------------------
    // full state of the slave front end
    // ------------------------------------------------------------------------
    typedef struct packed {
        i2csa_state_e  state;
        i2csa_state_e  after_ack;
        logic [3:0]    bit_cnt;
        logic [7:0]    rx_shift_reg;
        logic [7:0]    rx_buffer;
        logic [7:0]    own_address_reg;
        logic          bf;
        logic          ov;
        logic          irq_flag;
        logic          ua;
        logic          rw;
        logic          start_seen;
        logic          stop_seen;
        logic          ack_drive;
        logic          scl_hold;
        logic          hold_pending;
        logic          byte_ok;
        logic          second_addr;
        logic          ten_done;
        logic          scl_d;
        logic          sda_d;
    } i2csa_state_s;

endpackage

// >>> rtl/i2csa_sync.sv
// two flip-flop synchroniser for the bus pins
`timescale 1ns/100ps

module i2csa_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // bus lines idle high, so reset to high to avoid a false start
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta     <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// >>> testbench/i2csa_assertions.sv
// property checker for the i2c slave front end
`timescale 1ns/100ps

module i2csa_assertions (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   reset_n,
    // bus holds
    input wire logic                   scl_oe,
    input wire logic                   sda_oe,
    // firmware side
    input wire i2csa_pkg::i2csa_ctrl_s ctrl,
    input wire logic                   own_addr_wr,
    input wire logic                   rx_buffer_rd,
    input wire logic                   irq_flag_clr,
    input wire logic                   overflow_clr,
    input wire logic [7:0]             rx_buffer,
    input wire i2csa_pkg::i2csa_status_s status,
    input wire logic                   irq
);
    import i2csa_pkg::*;

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // ack lasts one bus clock period, about eight core clocks
    sequence ack_hold;
        sda_oe [*6];
    endsequence
    sequence ack_gone;
        !sda_oe;
    endsequence

    chk_ack_width: assert property ($rose(sda_oe) |-> ack_hold ##[1:6] ack_gone)
        else $error("ack pulse width wrong");
    chk_ack_cause: assert property ($rose(sda_oe) |->
        status.buffer_full_flag && !status.receive_overflow_flag && !$past(status.buffer_full_flag))
        else $error("ack given with full or overflow");
    chk_buf_hold: assert property (rx_buffer != $past(rx_buffer) |-> $rose(status.buffer_full_flag))
        else $error("buffer changed without full flag rising");
    chk_buf_read: assert property (rx_buffer_rd |=> !status.buffer_full_flag)
        else $error("buffer read left full flag set");
    chk_ov_sticky: assert property (status.receive_overflow_flag && !overflow_clr |=> status.receive_overflow_flag)
        else $error("overflow flag dropped without software");
    chk_irq_sticky: assert property (status.serial_port_irq_flag && !irq_flag_clr |=> status.serial_port_irq_flag)
        else $error("irq flag dropped without software");
    chk_irq_gate: assert property (irq == (status.serial_port_irq_flag && ctrl.irq_enable))
        else $error("irq output not gated by enable");
    chk_ua_release: assert property (own_addr_wr && status.address_update_flag |=>
        !status.address_update_flag ##1 !scl_oe)
        else $error("address write did not release hold");
    chk_hold_cause: assert property ($rose(scl_oe) |-> status.address_update_flag && ctrl.ten_bit_mode)
        else $error("clock held without address update");
    chk_ua_cause: assert property ($rose(status.address_update_flag) |->
        ctrl.ten_bit_mode && status.buffer_full_flag)
        else $error("address update outside ten bit mode");
endmodule

bind i2csa_slave i2csa_assertions i2csa_assertions_inst (
    .core_clk(core_clk), .reset_n(reset_n), .scl_oe(scl_oe), .sda_oe(sda_oe), .ctrl(ctrl),
    .own_addr_wr(own_addr_wr), .rx_buffer_rd(rx_buffer_rd), .irq_flag_clr(irq_flag_clr),
    .overflow_clr(overflow_clr), .rx_buffer(rx_buffer), .status(status), .irq(irq)
);

// >>> testbench/i2csa_master_model.sv
// behavioural i2c bus master that drives the slave front end
`timescale 1ns/100ps

module i2csa_master_model (
    // wired bus levels
    input  wire logic scl_line,
    input  wire logic sda_line,
    // open drain pulls
    output logic      scl_low,
    output logic      sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // release clock, wait out a stretch (bounded), then half the high time
    task automatic clk_high();
        scl_low = 1'b0;
        for (int n = 0; n < 2000 && !scl_line; n++) #25;
        #50;
    endtask

    // start and repeated start: data falls while clock is high
    task automatic start();
        #50;
        sda_low = 1'b0;
        #50;
        clk_high();
        sda_low = 1'b1;
        #100;
        scl_low = 1'b1;
    endtask

    task automatic stop();
        #50;
        sda_low = 1'b1;
        #50;
        clk_high();
        sda_low = 1'b0;
        #200;
    endtask

    // msb first, data steady around each rising clock edge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #50;
            sda_low = ~b[i];
            #50;
            clk_high();
            #50;
            scl_low = 1'b1;
        end
        #50;
        sda_low = 1'b0;
        #50;
        clk_high();
        ack = !sda_line;
        #50;
        scl_low = 1'b1;
        #150;
    endtask
endmodule

// >>> testbench/i2csa_slave_tb.sv
// self-checking bench for the i2c slave front end
`timescale 1ns/100ps

module i2csa_slave_tb;
    import i2csa_pkg::*;

    logic          core_clk, reset_n, own_addr_wr, rx_buffer_rd, irq_flag_clr, overflow_clr, ack;
    logic          scl_out, scl_oe, sda_out, sda_oe, irq, m_scl_low, m_sda_low;
    logic [7:0]    own_addr_wdata, rx_buffer, own_address_reg, b, exp_buf;
    logic [9:0]    ten;
    i2csa_ctrl_s   ctrl;
    i2csa_status_s status;
    int            error_cnt, tests_run, seed;
    // pull-ups on both bus lines
    wire logic     scl_line = !m_scl_low && !(scl_oe && !scl_out);
    wire logic     sda_line = !m_sda_low && !(sda_oe && !sda_out);

    i2csa_slave i2csa_slave_inst (
        .core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl), .own_addr_wr(own_addr_wr),
        .own_addr_wdata(own_addr_wdata), .rx_buffer_rd(rx_buffer_rd), .irq_flag_clr(irq_flag_clr),
        .overflow_clr(overflow_clr), .rx_buffer(rx_buffer), .own_address_reg(own_address_reg),
        .status(status), .irq(irq)
    );
    i2csa_master_model i2csa_master_model_inst (
        .scl_line(scl_line), .sda_line(sda_line), .scl_low(m_scl_low), .sda_low(m_sda_low)
    );

    always #12.5 core_clk = ~core_clk;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // expected status word and irq output while a frame is open
    task automatic st(input logic bf, input logic ov, input logic fl, input logic ua, input logic rw);
        check("status", {1'b0, status}, {1'b0, bf, ov, fl, ua, rw, 2'b10});
        check("irq", {7'h00, irq}, {7'h00, fl & ctrl.irq_enable});
    endtask

    // firmware pulse: 0 own address write, 1 buffer read, 2 irq clear, 3 overflow clear
    task automatic fw(input int k, input logic [7:0] d);
        @(negedge core_clk);
        own_addr_wdata = d;
        {own_addr_wr, rx_buffer_rd, irq_flag_clr, overflow_clr} = {k == 0, k == 1, k == 2, k == 3};
        @(negedge core_clk);
        {own_addr_wr, rx_buffer_rd, irq_flag_clr, overflow_clr} = 4'h0;
        @(negedge core_clk);
    endtask

    task automatic xfer(input logic [7:0] d, input logic exp_ack);
        i2csa_master_model_inst.send_byte(d, ack);
        @(negedge core_clk);
        check("ack", {7'h00, ack}, {7'h00, exp_ack});
    endtask

    function automatic logic [7:0] hdr(input logic [9:0] a);
        return {5'h1e, a[9:8], 1'b0};
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #500000;
        error_cnt++;
        test_done();
    end

    initial begin
        seed = 32'h1981e708;
        {core_clk, reset_n, own_addr_wr, rx_buffer_rd, irq_flag_clr, overflow_clr} = 6'h00;
        own_addr_wdata = 8'h00;
        ctrl = '{enable: 1'b1, ten_bit_mode: 1'b0, irq_enable: 1'b0};
        error_cnt = 0;
        tests_run = 0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        check("rx_buffer", rx_buffer, 8'h00);
        check("status", {1'b0, status}, 8'h00);
        check("holds", {6'h00, scl_oe, sda_oe}, 8'h00);
        repeat (4) @(negedge core_clk);
        for (int r = 0; r < 2; r++) begin
            ctrl.irq_enable = r[0];
            b = 8'($random(seed)) & 8'hfe;
            fw(0, b);
            check("own_address_reg", own_address_reg, b);
            i2csa_master_model_inst.start();
            xfer(b ^ 8'h02, 1'b0);
            xfer(8'h55, 1'b0);
            st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            i2csa_master_model_inst.start();
            xfer(b, 1'b1);
            check("rx_buffer", rx_buffer, b);
            st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
            exp_buf = b;
            b = 8'($random(seed));
            xfer(b, 1'b0);
            check("rx_buffer", rx_buffer, exp_buf);
            st(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
            fw(1, 8'h00);
            fw(2, 8'h00);
            st(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            xfer(b, 1'b0);
            check("rx_buffer", rx_buffer, b);
            st(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
            fw(1, 8'h00);
            fw(2, 8'h00);
            fw(3, 8'h00);
            xfer(~b, 1'b1);
            check("rx_buffer", rx_buffer, ~b);
            st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
            fw(1, 8'h00);
            fw(2, 8'h00);
            i2csa_master_model_inst.stop();
        end
        ctrl.ten_bit_mode = 1'b1;
        ten = 10'($random(seed));
        fw(0, hdr(ten));
        i2csa_master_model_inst.start();
        xfer(hdr(ten), 1'b1);
        st(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        check("scl_hold", {7'h00, scl_oe}, 8'h01);
        fw(0, ten[7:0]);
        check("scl_hold", {7'h00, scl_oe}, 8'h00);
        st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        fw(1, 8'h00);
        fw(2, 8'h00);
        xfer(ten[7:0], 1'b1);
        check("rx_buffer", rx_buffer, ten[7:0]);
        st(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        fw(0, hdr(ten));
        fw(1, 8'h00);
        fw(2, 8'h00);
        b = 8'($random(seed));
        xfer(b, 1'b1);
        check("rx_buffer", rx_buffer, b);
        fw(1, 8'h00);
        fw(2, 8'h00);
        i2csa_master_model_inst.start();
        xfer(hdr(ten) | 8'h01, 1'b1);
        st(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        check("scl_hold", {7'h00, scl_oe}, 8'h00);
        i2csa_master_model_inst.stop();
        // stop seen, start cleared, flags of the last byte kept
        check("status", {1'b0, status}, 8'h55);
        // a disabled front end ignores even a matching frame
        ctrl.enable = 1'b0;
        i2csa_master_model_inst.start();
        xfer(hdr(ten), 1'b0);
        i2csa_master_model_inst.stop();
        check("status", {1'b0, status}, 8'h54);
        test_done();
    end
endmodule
